// ==== core/scgc_comb.sv ====
`timescale 1ns/10ps
module scgc_comb #(
  parameter int unsigned WIDTH = 40
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  input wire logic enable,
  input wire logic [WIDTH-1:0] x,
  output logic [WIDTH-1:0] y
);
  logic [WIDTH-1:0] delayed;
  logic [WIDTH-1:0] next_delayed;

  if (WIDTH < 2) begin : g_width_check
    $error("scgc_comb width too small");
  end

  // Differentiator: the wrapped difference stays exact in modular arithmetic.
  always_comb begin
    next_delayed = delayed;
    if (clear) begin
      next_delayed = '0;
    end else if (enable) begin
      next_delayed = x;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      delayed <= '0;
    end else begin
      delayed <= next_delayed;
    end
  end

  assign y = x - delayed;
endmodule : scgc_comb

// ==== core/scgc_pkg.sv ====
package scgc_pkg;
  localparam int unsigned SCGC_WORD_W = 40;
  localparam int unsigned SCGC_CODE_W = 11;
  localparam int unsigned SCGC_GAIN_W = 3;
  localparam int unsigned SCGC_ADDR_W = 8;
  localparam int unsigned SCGC_DATA_W = 32;

  localparam logic [7:0] SCGC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SCGC_ADDR_NOTCH = 8'h04;
  localparam logic [7:0] SCGC_ADDR_DATA_LO = 8'h08;
  localparam logic [7:0] SCGC_ADDR_DATA_HI = 8'h0C;
  localparam logic [7:0] SCGC_ADDR_STATUS = 8'h10;

  localparam int unsigned SCGC_GAIN_LSB = 0;
  localparam int unsigned SCGC_BURNOUT_BIT = 4;
  localparam int unsigned SCGC_BIPOLAR_BIT = 5;
  localparam int unsigned SCGC_TWOS_BIT = 6;
  localparam int unsigned SCGC_ST_NEW_BIT = 0;
  localparam int unsigned SCGC_ST_SETTLED_BIT = 1;

  localparam logic [2:0] SCGC_GAIN_RESET = 3'h0;
  localparam logic SCGC_BIPOLAR_RESET = 1'b1;
  localparam logic SCGC_TWOS_RESET = 1'b0;
  localparam logic SCGC_BURNOUT_RESET = 1'b0;
  localparam logic [10:0] SCGC_NOTCH_RESET = 11'h28B;
  localparam logic [10:0] SCGC_NOTCH_MIN = 11'h00A;

  localparam int unsigned SCGC_MOD_DIV = 128;
  localparam int unsigned SCGC_DIV_G1 = 128;
  localparam int unsigned SCGC_DIV_G2 = 64;
  localparam int unsigned SCGC_DIV_G4 = 32;
  localparam int unsigned SCGC_DIV_G8 = 16;
  localparam int unsigned SCGC_DECIM_MULT = 4;
  localparam int unsigned SCGC_FRONT_MAX = 3;
  localparam logic [1:0] SCGC_SETTLE_OUTPUTS = 2'h3;

  typedef enum logic [1:0] {
    SCGC_SETTLE = 2'b01,
    SCGC_RUN = 2'b10
  } scgc_state_t;
endpackage : scgc_pkg

// ==== core/scgc_top.sv ====
`timescale 1ns/10ps
// How it works
// - A modulator strobe every 128 master clocks takes one modulator bit.
// - Each modulator bit becomes a signed 40-bit word of plus or minus one.
// - The decimator is a three-stage integrator-comb chain with adders only.
// - Decimation spans 512 times the notch code master clocks.
// - The notch code is 11 bits and codes below 10 are raised to 10.
// - One filtered word is emitted per notch period.
// - Gains 1 to 8 go to the front end and gains 16 to 128 are digital left shifts.
// - The front-end sample strobe runs at master over 128, 64, 32 or 16 by gain.
// - Gain is a software field of the control register.
// - A polarity bit picks bipolar or unipolar and also drives the bipolar_mode output to the front end.
// - Control bit 4 drives the burn-out source and clears at reset.
// - The 40-bit wrapping datapath never saturates inside the filter.
// - Output coding is two's complement or offset binary when bipolar, straight binary when unipolar.
// - After a restart the first three words are withheld so output settles within 3 to 4 periods.
module scgc_top
  import scgc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [scgc_pkg::SCGC_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scgc_pkg::SCGC_DATA_W-1:0] pwdata,
  output logic [scgc_pkg::SCGC_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mod_bit,
  output logic mod_strobe,
  output logic sample_strobe,
  output logic [1:0] front_gain_amplifier,
  output logic burnout_source_enable,
  output logic bipolar_mode,
  output logic [scgc_pkg::SCGC_WORD_W-1:0] data_word,
  output logic data_valid
);
  import scgc_pkg::*;

  localparam int unsigned W = SCGC_WORD_W;

  // Control and bus state.
  logic [2:0] gain_code, next_gain_code;
  logic bipolar, next_bipolar;
  logic twos, next_twos;
  logic burnout, next_burnout;
  logic [10:0] notch_code, next_notch_code;
  logic restart, next_restart;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic new_flag, next_new_flag;
  logic [W-1:0] next_data_word;
  logic next_data_valid;

  // Timing and filter state.
  logic mod_sync1, mod_sync2;
  logic [6:0] mod_cnt, next_mod_cnt;
  logic next_mod_strobe, next_sample_strobe;
  logic [12:0] decim_cnt, next_decim_cnt;
  logic [W-1:0] integ [0:2];
  logic [W-1:0] next_integ [0:2];
  logic [W-1:0] comb_y [0:3];
  logic dec_tick;
  logic [1:0] settle_cnt, next_settle_cnt;
  scgc_state_t state, next_state;

  logic wr_take, rd_take;
  logic [12:0] decim_last;
  logic [6:0] sample_mask;
  logic [2:0] dig_shift;
  logic [W+3:0] scaled;
  logic [W-1:0] sat_word, coded;
  logic [W-1:0] bit_word;

  if (W < 40) begin : g_width_check
    $error("scgc_top word width must hold the sinc3 growth");
  end

  assign wr_take = psel && penable && pwrite && !pready;
  assign rd_take = psel && penable && !pwrite && !pready;

  // APB slave: one wait state, write lands at the edge where pready is sampled high.
  always_comb begin
    next_gain_code = gain_code;
    next_bipolar = bipolar;
    next_twos = twos;
    next_burnout = burnout;
    next_notch_code = notch_code;
    next_restart = 1'b0;
    next_pready = psel && penable && !pready;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (psel && penable && pready && pwrite) begin
      case (paddr)
        SCGC_ADDR_CTRL: begin
          next_gain_code = pwdata[SCGC_GAIN_LSB +: SCGC_GAIN_W];
          next_burnout = pwdata[SCGC_BURNOUT_BIT];
          next_bipolar = pwdata[SCGC_BIPOLAR_BIT];
          next_twos = pwdata[SCGC_TWOS_BIT];
          next_restart = 1'b1;
        end
        SCGC_ADDR_NOTCH: begin
          if (pwdata[10:0] < SCGC_NOTCH_MIN) begin
            next_notch_code = SCGC_NOTCH_MIN;
          end else begin
            next_notch_code = pwdata[10:0];
          end
          next_restart = 1'b1;
        end
        default: begin
          next_restart = 1'b0;
        end
      endcase
    end
    if (wr_take || rd_take) begin
      case (paddr)
        SCGC_ADDR_CTRL: begin
          next_prdata[SCGC_GAIN_LSB +: SCGC_GAIN_W] = gain_code;
          next_prdata[SCGC_BURNOUT_BIT] = burnout;
          next_prdata[SCGC_BIPOLAR_BIT] = bipolar;
          next_prdata[SCGC_TWOS_BIT] = twos;
        end
        SCGC_ADDR_NOTCH: next_prdata[10:0] = notch_code;
        SCGC_ADDR_DATA_LO: next_prdata = data_word[31:0];
        SCGC_ADDR_DATA_HI: next_prdata[W-33:0] = data_word[W-1:32];
        SCGC_ADDR_STATUS: begin
          next_prdata[SCGC_ST_NEW_BIT] = new_flag;
          next_prdata[SCGC_ST_SETTLED_BIT] = (state == SCGC_RUN);
        end
        default: next_pslverr = 1'b1;
      endcase
      if (!pwrite) begin
        next_prdata = next_pslverr ? 32'h0000_0000 : next_prdata;
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      gain_code <= SCGC_GAIN_RESET;
      bipolar <= SCGC_BIPOLAR_RESET;
      twos <= SCGC_TWOS_RESET;
      burnout <= SCGC_BURNOUT_RESET;
      notch_code <= SCGC_NOTCH_RESET;
      restart <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      gain_code <= next_gain_code;
      bipolar <= next_bipolar;
      twos <= next_twos;
      burnout <= next_burnout;
      notch_code <= next_notch_code;
      restart <= next_restart;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Modulator bit comes from the analog side and is synchronised first.
  always_ff @(posedge clock) begin
    if (rst) begin
      mod_sync1 <= 1'b0;
      mod_sync2 <= 1'b0;
    end else begin
      mod_sync1 <= mod_bit;
      mod_sync2 <= mod_sync1;
    end
  end

  // Front-end sampling speeds up with gain; the modulator output rate stays fixed.
  always_comb begin
    case (gain_code)
      3'h0: sample_mask = 7'(SCGC_DIV_G1 - 1);
      3'h1: sample_mask = 7'(SCGC_DIV_G2 - 1);
      3'h2: sample_mask = 7'(SCGC_DIV_G4 - 1);
      default: sample_mask = 7'(SCGC_DIV_G8 - 1);
    endcase
    next_mod_cnt = restart ? 7'h00 : 7'(mod_cnt + 7'h01);
    next_mod_strobe = !restart && (mod_cnt == 7'(SCGC_MOD_DIV - 1));
    next_sample_strobe = !restart && ((mod_cnt & sample_mask) == sample_mask);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mod_cnt <= 7'h00;
      mod_strobe <= 1'b0;
      sample_strobe <= 1'b0;
      front_gain_amplifier <= 2'h0;
      burnout_source_enable <= 1'b0;
      bipolar_mode <= 1'b1;
    end else begin
      mod_cnt <= next_mod_cnt;
      mod_strobe <= next_mod_strobe;
      sample_strobe <= next_sample_strobe;
      front_gain_amplifier <= (gain_code > 3'(SCGC_FRONT_MAX)) ? 2'(SCGC_FRONT_MAX) : gain_code[1:0];
      burnout_source_enable <= burnout;
      bipolar_mode <= bipolar;
    end
  end

  // Integrator section runs once per modulator bit.
  assign bit_word = mod_sync2 ? {{(W-1){1'b0}}, 1'b1} : {W{1'b1}};
  assign decim_last = 13'(SCGC_DECIM_MULT * notch_code - 1);
  assign dec_tick = mod_strobe && (decim_cnt == decim_last);

  always_comb begin
    next_integ[0] = integ[0];
    next_integ[1] = integ[1];
    next_integ[2] = integ[2];
    next_decim_cnt = decim_cnt;
    if (restart) begin
      next_integ[0] = '0;
      next_integ[1] = '0;
      next_integ[2] = '0;
      next_decim_cnt = 13'h0000;
    end else if (mod_strobe) begin
      next_integ[0] = integ[0] + bit_word;
      next_integ[1] = integ[1] + integ[0];
      next_integ[2] = integ[2] + integ[1];
      next_decim_cnt = dec_tick ? 13'h0000 : 13'(decim_cnt + 13'h0001);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      integ[0] <= '0;
      integ[1] <= '0;
      integ[2] <= '0;
      decim_cnt <= 13'h0000;
    end else begin
      integ[0] <= next_integ[0];
      integ[1] <= next_integ[1];
      integ[2] <= next_integ[2];
      decim_cnt <= next_decim_cnt;
    end
  end

  assign comb_y[0] = integ[2];

  generate
    for (genvar k = 0; k < 3; k++) begin : g_comb
      scgc_comb #(
        .WIDTH(W)
      ) u_comb (
        .clock(clock),
        .rst(rst),
        .clear(restart),
        .enable(dec_tick),
        .x(comb_y[k]),
        .y(comb_y[k+1])
      );
    end
  endgenerate

  // Digital gain for 16 and up, then output coding.
  always_comb begin
    dig_shift = (gain_code > 3'(SCGC_FRONT_MAX)) ? 3'(gain_code - 3'(SCGC_FRONT_MAX)) : 3'h0;
    scaled = {{4{comb_y[3][W-1]}}, comb_y[3]} <<< dig_shift;
    if (scaled[W+3:W-1] != {5{scaled[W+3]}}) begin
      sat_word = scaled[W+3] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
    end else begin
      sat_word = scaled[W-1:0];
    end
    if (!bipolar) begin
      coded = sat_word[W-1] ? '0 : sat_word;
    end else if (twos) begin
      coded = sat_word;
    end else begin
      coded = {~sat_word[W-1], sat_word[W-2:0]};
    end
  end

  // Settling: the first three words after a restart carry pipeline history.
  always_comb begin
    next_state = state;
    next_settle_cnt = settle_cnt;
    next_data_word = data_word;
    next_data_valid = 1'b0;
    next_new_flag = new_flag;
    if (rd_take && (paddr == SCGC_ADDR_DATA_LO)) begin
      next_new_flag = 1'b0;
    end
    if (restart) begin
      next_state = SCGC_SETTLE;
      next_settle_cnt = 2'h0;
    end else if (dec_tick) begin
      case (state)
        SCGC_SETTLE: begin
          next_settle_cnt = 2'(settle_cnt + 2'h1);
          if (settle_cnt == SCGC_SETTLE_OUTPUTS - 2'h1) begin
            next_state = SCGC_RUN;
          end
        end
        SCGC_RUN: begin
          next_data_word = coded;
          next_data_valid = 1'b1;
          next_new_flag = 1'b1;
        end
        default: next_state = SCGC_SETTLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= SCGC_SETTLE;
      settle_cnt <= 2'h0;
      data_word <= '0;
      data_valid <= 1'b0;
      new_flag <= 1'b0;
    end else begin
      state <= next_state;
      settle_cnt <= next_settle_cnt;
      data_word <= next_data_word;
      data_valid <= next_data_valid;
      new_flag <= next_new_flag;
    end
  end
endmodule : scgc_top

// ==== tb/scgc_chk.sv ====
`timescale 1ns/10ps
module scgc_chk
  import scgc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [scgc_pkg::SCGC_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scgc_pkg::SCGC_DATA_W-1:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mod_strobe,
  input wire logic sample_strobe,
  input wire logic [1:0] front_gain_amplifier,
  input wire logic burnout_source_enable,
  input wire logic bipolar_mode,
  input wire logic data_valid
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  logic wr_cfg;
  logic wr_q;
  logic mapped;
  logic s_mod;
  logic s_smp;
  logic first;
  logic [10:0] notch;
  int unsigned c_mod;
  int unsigned c_smp;
  int unsigned c_dv;
  int unsigned per;
  assign wr_cfg = psel && penable && pready && pwrite && paddr inside {SCGC_ADDR_CTRL, SCGC_ADDR_NOTCH};
  assign per = SCGC_MOD_DIV * SCGC_DECIM_MULT * notch;
  assign mapped = paddr inside {SCGC_ADDR_CTRL, SCGC_ADDR_NOTCH, SCGC_ADDR_DATA_LO, SCGC_ADDR_DATA_HI, SCGC_ADDR_STATUS};
  // A period is judged only from the second strobe after reset or reconfiguration.
  always_ff @(posedge clock) begin
    c_mod <= mod_strobe ? 0 : c_mod + 1;
    c_smp <= sample_strobe ? 0 : c_smp + 1;
    // The filter restarts one cycle after the write, so a word of the old setting may still appear at that edge.
    wr_q <= wr_cfg;
    c_dv <= (rst || data_valid || wr_q) ? 0 : c_dv + 1;
    s_mod <= !rst && !wr_cfg && (s_mod || mod_strobe);
    s_smp <= !rst && !wr_cfg && (s_smp || sample_strobe);
    first <= rst || wr_q || (first && !data_valid);
    if (rst)
      notch <= SCGC_NOTCH_RESET;
    else if (wr_cfg && paddr == SCGC_ADDR_NOTCH)
      notch <= (pwdata[10:0] < SCGC_NOTCH_MIN) ? SCGC_NOTCH_MIN : pwdata[10:0];
  end
  sequence s_ctrl_wr;
    psel && penable && pready && pwrite && paddr == SCGC_ADDR_CTRL;
  endsequence
  AST_READY: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  AST_ERR: assert property (pslverr |-> pready && !mapped)
    else $error("pslverr wrong");
  AST_MOD: assert property (mod_strobe && s_mod |-> c_mod == SCGC_MOD_DIV - 1)
    else $error("mod strobe period");
  AST_SMP: assert property (sample_strobe && s_smp |-> c_smp == (SCGC_DIV_G1 >> front_gain_amplifier) - 1)
    else $error("sample strobe period");
  AST_GAIN: assert property (s_ctrl_wr |-> ##2 front_gain_amplifier == (($past(pwdata[2:0], 2) > 3) ? 2'h3 : $past(pwdata[1:0], 2)))
    else $error("gain output");
  AST_BURN: assert property (s_ctrl_wr |-> ##2 burnout_source_enable == $past(pwdata[4], 2))
    else $error("burnout output");
  AST_POL: assert property (s_ctrl_wr |-> ##2 bipolar_mode == $past(pwdata[5], 2))
    else $error("polarity output");
  AST_PULSE: assert property (data_valid |=> !data_valid)
    else $error("valid too long");
  AST_PER: assert property (data_valid && !first |-> c_dv == per - 1)
    else $error("output period");
  AST_SETTLE: assert property (data_valid && first |-> c_dv >= 3 * per && c_dv <= 4 * per + 8)
    else $error("settling span");
endmodule : scgc_chk
bind scgc_top scgc_chk i_scgc_chk (.clock(clock), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .mod_strobe(mod_strobe),
  .sample_strobe(sample_strobe), .front_gain_amplifier(front_gain_amplifier),
  .burnout_source_enable(burnout_source_enable), .bipolar_mode(bipolar_mode), .data_valid(data_valid));

// ==== tb/scgc_mod_model.sv ====
`timescale 1ns/10ps
module scgc_mod_model
  import scgc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic mod_strobe,
  input wire logic level,
  input wire logic data_valid,
  input wire logic [scgc_pkg::SCGC_WORD_W-1:0] data_word,
  output logic mod_bit,
  output logic [scgc_pkg::SCGC_WORD_W-1:0] last_word,
  output int unsigned n_words
);
  // The modulator moves to its next bit after each strobe; the calibration side keeps the latest word and counts the words.
  always_ff @(posedge clock) begin
    if (rst) begin
      mod_bit <= 1'b0;
      last_word <= '0;
      n_words <= 0;
    end else begin
      if (mod_strobe)
        mod_bit <= level;
      if (data_valid) begin
        last_word <= data_word;
        n_words <= n_words + 1;
      end
    end
  end
endmodule : scgc_mod_model

// ==== tb/scgc_top_bench.sv ====
`timescale 1ns/10ps
module scgc_top_bench;
  import scgc_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} scgc_row_t;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, level, er;
  logic mod_bit, mod_strobe, sample_strobe, burnout_source_enable, bipolar_mode, data_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] front_gain_amplifier;
  logic [39:0] data_word, last_word;
  int unsigned n_words;
  int num_errors, compares;
  scgc_row_t rows[10];
  scgc_top i_scgc_top (.clock(clock), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mod_bit(mod_bit),
    .mod_strobe(mod_strobe), .sample_strobe(sample_strobe), .front_gain_amplifier(front_gain_amplifier),
    .burnout_source_enable(burnout_source_enable), .bipolar_mode(bipolar_mode), .data_word(data_word),
    .data_valid(data_valid));
  scgc_mod_model i_scgc_mod_model (.clock(clock), .rst(rst), .mod_strobe(mod_strobe), .level(level),
    .data_valid(data_valid), .data_word(data_word), .mod_bit(mod_bit), .last_word(last_word), .n_words(n_words));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run(input logic [31:0] c, input logic l, input logic [39:0] e, input int k);
    int unsigned n0;
    level <= l;
    repeat (4) @(posedge clock);
    apb(SCGC_ADDR_CTRL, 1'b1, c);
    n0 = n_words;
    for (int n = 0; n < 30000 && n_words < n0 + k; n++)
      @(posedge clock);
    chk("words", 40'(n0 + k), 40'(n_words));
    chk("word", e, last_word);
  endtask : run
  task automatic report_and_stop();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (96000) @(posedge clock);
    num_errors++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, level} = '0;
    paddr = '0;
    pwdata = '0;
    rows = '{'{SCGC_ADDR_CTRL, 32'h51, 32'h51, 0}, '{SCGC_ADDR_CTRL, 32'h02, 32'h02, 0},
      '{SCGC_ADDR_CTRL, 32'h33, 32'h33, 0}, '{SCGC_ADDR_CTRL, 32'h14, 32'h14, 0},
      '{SCGC_ADDR_CTRL, 32'h25, 32'h25, 0}, '{SCGC_ADDR_CTRL, 32'h06, 32'h06, 0},
      '{SCGC_ADDR_NOTCH, 32'h7FF, 32'h7FF, 0}, '{SCGC_ADDR_NOTCH, 32'h009, 32'h00A, 0},
      '{8'h14, 32'h1, 32'h0, 1}, '{SCGC_ADDR_DATA_HI, 32'hFF, 32'h0, 0}};
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("burnout", 40'(SCGC_BURNOUT_RESET), 40'(burnout_source_enable));
    chk("bipolar", 40'(SCGC_BIPOLAR_RESET), 40'(bipolar_mode));
    apb(SCGC_ADDR_CTRL, 1'b0, 0);
    chk("ctrl", 40'h20, 40'(rd));
    apb(SCGC_ADDR_NOTCH, 1'b0, 0);
    chk("notch", 40'(SCGC_NOTCH_RESET), 40'(rd));
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, rows[i].d);
      chk("wr_err", 40'(rows[i].e), 40'(er));
      apb(rows[i].a, 1'b0, 0);
      chk("rd", 40'(rows[i].q), 40'(rd));
      chk("rd_err", 40'(rows[i].e), 40'(er));
      repeat (300) @(posedge clock);
      if (rows[i].a == SCGC_ADDR_CTRL) begin
        chk("gain", 40'((rows[i].d[2:0] > 3) ? 3 : rows[i].d[2:0]), 40'(front_gain_amplifier));
        chk("burnout", 40'(rows[i].d[4]), 40'(burnout_source_enable));
        chk("bipolar", 40'(rows[i].d[5]), 40'(bipolar_mode));
      end
    end
    run(32'h60, 1'b1, 40'h000000FA00, 2);
    apb(SCGC_ADDR_STATUS, 1'b0, 0);
    chk("status", 40'h3, 40'(rd));
    apb(SCGC_ADDR_DATA_LO, 1'b0, 0);
    chk("data_lo", 40'h0000FA00, 40'(rd));
    apb(SCGC_ADDR_STATUS, 1'b0, 0);
    chk("status", 40'h2, 40'(rd));
    run(32'h27, 1'b1, 40'h80000FA000, 1);
    apb(SCGC_ADDR_DATA_HI, 1'b0, 0);
    chk("data_hi", 40'h80, 40'(rd));
    run(32'h67, 1'b0, 40'hFFFFF06000, 1);
    run(32'h00, 1'b0, 40'h0000000000, 1);
    // A reset in mid-run must bring back the power-up setting and drop the unread word.
    apb(SCGC_ADDR_CTRL, 1'b1, 32'h17);
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("burnout", 40'(SCGC_BURNOUT_RESET), 40'(burnout_source_enable));
    chk("bipolar", 40'(SCGC_BIPOLAR_RESET), 40'(bipolar_mode));
    chk("gain", 40'h0, 40'(front_gain_amplifier));
    apb(SCGC_ADDR_CTRL, 1'b0, 0);
    chk("ctrl", 40'h20, 40'(rd));
    apb(SCGC_ADDR_NOTCH, 1'b0, 0);
    chk("notch", 40'(SCGC_NOTCH_RESET), 40'(rd));
    apb(SCGC_ADDR_STATUS, 1'b0, 0);
    chk("status", 40'h0, 40'(rd));
    report_and_stop();
  end
endmodule : scgc_top_bench
